// File: overlay_regs_pkg.sv
// Purpose: constants and carrier types for the overlay window registers
// Assumes: 32-bit APB data, one aligned word per register
// Notes: offsets are byte addresses from the video processor base
package overlay_regs_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_W1_STRETCH = 8'h24;
	localparam logic [7:0] OFS_W2_LEFT_TOP = 8'h28;
	localparam logic [7:0] OFS_W2_RIGHT_BOT = 8'h2c;
	localparam logic [7:0] OFS_W2_SRC_START = 8'h30;
	localparam logic [7:0] OFS_W2_WIDTH_OFS = 8'h34;
	localparam logic [7:0] OFS_W2_STRETCH = 8'h38;

	// Field positions and widths
	localparam int COORD_W = 11;
	localparam int LO_LSB = 0;
	localparam int HI_LSB = 16;
	localparam int SRC_ADDR_W = 19;
	localparam int PEND_BIT = 19;
	localparam int LINE_W_W = 10;
	localparam int LINE_W_LSB = 16;
	localparam int LINE_OFS_W = 10;
	localparam int LINE_OFS_LSB = 0;
	localparam int SF_W = 8;

	// Values after reset
	localparam logic [31:0] RST_STRETCH = 32'h0000_0000;
	localparam logic [COORD_W-1:0] RST_COORD = 11'h000;
	localparam logic [SRC_ADDR_W-1:0] RST_SRC_ADDR = 19'h0_0000;
	localparam logic [LINE_W_W-1:0] RST_LINE = 10'h000;

	// Stretch register layout, msb first
	typedef struct packed {
		logic [SF_W-1:0] init_odd;
		logic [SF_W-1:0] init_even;
		logic [SF_W-1:0] horiz;
		logic [SF_W-1:0] vert;
	} stretch_t;

	// Screen boundaries of a window
	typedef struct packed {
		logic [COORD_W-1:0] top;
		logic [COORD_W-1:0] left;
		logic [COORD_W-1:0] bottom;
		logic [COORD_W-1:0] right;
	} bounds_t;

endpackage : overlay_regs_pkg

// File: scale_stepper.sv
// Purpose: horizontal and vertical source stepping from stretch factors
// Assumes: step strobes come from display timing on pclk
// Notes: a zero factor gives one source step per destination step
`timescale 1ns/1ns
module scale_stepper #(
	parameter int W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic field_start,
	input wire logic field_odd,
	input wire logic pixel_step,
	input wire logic line_step,
	input wire logic [W-1:0] hfactor,
	input wire logic [W-1:0] vfactor,
	input wire logic [W-1:0] init_odd,
	input wire logic [W-1:0] init_even,
	output logic src_pix_adv,
	output logic src_line_adv
);
	logic [W-1:0] hacc_q;
	logic [W-1:0] vacc_q;
	logic [W:0] hsum;
	logic [W:0] vsum;

	// Sums with carry; carry marks a whole source pixel or a repeat
	assign hsum = {1'b0, hacc_q} + {1'b0, hfactor};
	assign vsum = {1'b0, vacc_q} + {1'b0, vfactor};
	// Zero factor steps one to one
	assign src_pix_adv = pixel_step & ((hfactor == '0) | hsum[W]);
	assign src_line_adv = line_step & ((vfactor == '0) | ~vsum[W]);

	// Horizontal phase restarts each line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hacc_q <= '0;
		end else if (line_step) begin
			hacc_q <= '0;
		end else if (pixel_step) begin
			hacc_q <= hsum[W-1:0];
		end
	end

	// Vertical phase seeded per field, so odd and even lines interleave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vacc_q <= '0;
		end else if (field_start) begin
			vacc_q <= field_odd ? init_odd : init_even;
		end else if (line_step) begin
			vacc_q <= vsum[W-1:0];
		end
	end

endmodule : scale_stepper

// File: line_addr_gen.sv
// Purpose: source line fetch address in 64-bit units
// Assumes: frame_start and line_adv are one-cycle strobes on pclk
// Notes: the address wraps within its field width
`timescale 1ns/1ns
module line_addr_gen #(
	parameter int AW = 19,
	parameter int OW = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic frame_start,
	input wire logic [AW-1:0] base,
	input wire logic line_adv,
	input wire logic [OW-1:0] offset,
	output logic [AW-1:0] line_addr_q
);
	logic [AW-1:0] line_addr_d;

	// Offset must be narrower than the address it is added to
	if (OW < 1 || OW >= AW) begin : g_chk
		$error("OW must be between 1 and AW-1");
	end

	// Frame start wins, a frame never begins mid-pointer
	assign line_addr_d = frame_start ? base :
		AW'(line_addr_q + {{(AW-OW){1'b0}}, offset});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_addr_q <= '0;
		end else if (frame_start || line_adv) begin
			line_addr_q <= line_addr_d;
		end
	end

endmodule : line_addr_gen

// File: video_window_overlay_regs.sv
// Purpose: APB register bank placing and scaling overlay window two
// Assumes: timing strobes come from display logic on pclk
// Notes: zero wait states; unmapped addresses answer with pslverr
`timescale 1ns/1ns
module video_window_overlay_regs #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_start,
	input wire logic field_start,
	input wire logic field_odd,
	input wire logic pixel_step,
	input wire logic line_step,
	output overlay_regs_pkg::bounds_t win2_bounds,
	output logic [overlay_regs_pkg::SRC_ADDR_W-1:0] win2_fetch_addr,
	output logic [overlay_regs_pkg::LINE_W_W-1:0] win2_line_width,
	output logic win2_pix_adv,
	output logic win2_line_adv,
	output logic win1_pix_adv,
	output logic win1_line_adv,
	output logic start_addr_pending
);
	localparam int AW = overlay_regs_pkg::SRC_ADDR_W;
	localparam int CW = overlay_regs_pkg::COORD_W;
	localparam int LO = overlay_regs_pkg::LO_LSB;
	localparam int HI = overlay_regs_pkg::HI_LSB;

	// Decode needs the whole 8-bit offset space
	if (ADDR_W < 8) begin : g_chk
		$error("ADDR_W must be at least 8");
	end

	overlay_regs_pkg::stretch_t w1_stretch_q;
	overlay_regs_pkg::stretch_t w2_stretch_q;
	overlay_regs_pkg::bounds_t bounds_q;
	logic [AW-1:0] src_shadow_q;
	logic [AW-1:0] src_active_q;
	logic pend_q;
	logic pend_d;
	logic [overlay_regs_pkg::LINE_W_W-1:0] line_width_q;
	logic [overlay_regs_pkg::LINE_OFS_W-1:0] line_ofs_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_word;
	logic [AW-1:0] frame_base;

	// Address decode
	logic [7:0] ofs;
	logic hi_zero;
	logic sel_w1s;
	logic sel_lt;
	logic sel_rb;
	logic sel_src;
	logic sel_wo;
	logic sel_w2s;
	logic mapped;
	logic wr_en;
	logic setup;

	assign ofs = paddr[7:0];
	assign hi_zero = (paddr >> 8) == '0;
	assign sel_w1s = hi_zero && ofs == overlay_regs_pkg::OFS_W1_STRETCH;
	assign sel_lt = hi_zero && ofs == overlay_regs_pkg::OFS_W2_LEFT_TOP;
	assign sel_rb = hi_zero && ofs == overlay_regs_pkg::OFS_W2_RIGHT_BOT;
	assign sel_src = hi_zero && ofs == overlay_regs_pkg::OFS_W2_SRC_START;
	assign sel_wo = hi_zero && ofs == overlay_regs_pkg::OFS_W2_WIDTH_OFS;
	assign sel_w2s = hi_zero && ofs == overlay_regs_pkg::OFS_W2_STRETCH;
	assign mapped = sel_w1s | sel_lt | sel_rb | sel_src | sel_wo | sel_w2s;
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & mapped;

	// Every access completes at once; error only for unmapped offsets
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_q;

	// Read mux; reserved bits read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (sel_w1s) begin
			rd_word = w1_stretch_q;
		end else if (sel_lt) begin
			rd_word[HI+:CW] = bounds_q.top;
			rd_word[LO+:CW] = bounds_q.left;
		end else if (sel_rb) begin
			rd_word[HI+:CW] = bounds_q.bottom;
			rd_word[LO+:CW] = bounds_q.right;
		end else if (sel_src) begin
			rd_word[AW-1:0] = src_shadow_q;
			rd_word[overlay_regs_pkg::PEND_BIT] = pend_q;
		end else if (sel_wo) begin
			rd_word[overlay_regs_pkg::LINE_W_LSB+:overlay_regs_pkg::LINE_W_W] =
				line_width_q;
			rd_word[overlay_regs_pkg::LINE_OFS_LSB+:overlay_regs_pkg::LINE_OFS_W]
				= line_ofs_q;
		end else if (sel_w2s) begin
			rd_word = w2_stretch_q;
		end
	end

	// Read data captured in setup, stable through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= rd_word;
		end
	end

	// Stretch registers, same layout for both windows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			w1_stretch_q <= overlay_regs_pkg::RST_STRETCH;
			w2_stretch_q <= overlay_regs_pkg::RST_STRETCH;
		end else begin
			if (wr_en && sel_w1s) w1_stretch_q <= pwdata;
			if (wr_en && sel_w2s) w2_stretch_q <= pwdata;
		end
	end

	// Boundary fields taken from their bit ranges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bounds_q <= {4{overlay_regs_pkg::RST_COORD}};
		end else if (wr_en && sel_lt) begin
			bounds_q.top <= pwdata[HI+:CW];
			bounds_q.left <= pwdata[LO+:CW];
		end else if (wr_en && sel_rb) begin
			bounds_q.bottom <= pwdata[HI+:CW];
			bounds_q.right <= pwdata[LO+:CW];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_width_q <= overlay_regs_pkg::RST_LINE;
			line_ofs_q <= overlay_regs_pkg::RST_LINE;
		end else if (wr_en && sel_wo) begin
			line_width_q <=
				pwdata[overlay_regs_pkg::LINE_W_LSB+:overlay_regs_pkg::LINE_W_W];
			line_ofs_q <=
				pwdata[overlay_regs_pkg::LINE_OFS_LSB+:overlay_regs_pkg::LINE_OFS_W];
		end
	end

	// Pending flag; a write in a frame-start cycle wins
	// so the fresh address is not mistaken as already taken
	assign pend_d = (wr_en && sel_src) ? pwdata[overlay_regs_pkg::PEND_BIT] :
		(frame_start ? 1'b0 : pend_q);

	// Shadow written by software, active moved only at frame start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_shadow_q <= overlay_regs_pkg::RST_SRC_ADDR;
			src_active_q <= overlay_regs_pkg::RST_SRC_ADDR;
			pend_q <= 1'b0;
		end else begin
			if (wr_en && sel_src) src_shadow_q <= pwdata[AW-1:0];
			if (frame_start && pend_q) src_active_q <= src_shadow_q;
			pend_q <= pend_d;
		end
	end

	// Frame fetch begins at the address taking effect now
	assign frame_base = pend_q ? src_shadow_q : src_active_q;

	assign win2_bounds = bounds_q;
	assign win2_line_width = line_width_q;
	assign start_addr_pending = pend_q;

	scale_stepper #(
		.W(overlay_regs_pkg::SF_W)
	) u_win2_step (
		.pclk(pclk),
		.presetn(presetn),
		.field_start(field_start),
		.field_odd(field_odd),
		.pixel_step(pixel_step),
		.line_step(line_step),
		.hfactor(w2_stretch_q.horiz),
		.vfactor(w2_stretch_q.vert),
		.init_odd(w2_stretch_q.init_odd),
		.init_even(w2_stretch_q.init_even),
		.src_pix_adv(win2_pix_adv),
		.src_line_adv(win2_line_adv)
	);

	// Window one stepping, field seeds set the vertical phase of each field
	scale_stepper #(
		.W(overlay_regs_pkg::SF_W)
	) u_win1_step (
		.pclk(pclk),
		.presetn(presetn),
		.field_start(field_start),
		.field_odd(field_odd),
		.pixel_step(pixel_step),
		.line_step(line_step),
		.hfactor(w1_stretch_q.horiz),
		.vfactor(w1_stretch_q.vert),
		.init_odd(w1_stretch_q.init_odd),
		.init_even(w1_stretch_q.init_even),
		.src_pix_adv(win1_pix_adv),
		.src_line_adv(win1_line_adv)
	);

	// Line pointer advances by the programmed offset
	line_addr_gen #(
		.AW(AW),
		.OW(overlay_regs_pkg::LINE_OFS_W)
	) u_win2_addr (
		.pclk(pclk),
		.presetn(presetn),
		.frame_start(frame_start),
		.base(frame_base),
		.line_adv(win2_line_adv),
		.offset(line_ofs_q),
		.line_addr_q(win2_fetch_addr)
	);

	// Checks on the design's own outputs and internal state
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence src_write_pend_s;
		wr_en && sel_src && pwdata[overlay_regs_pkg::PEND_BIT];
	endsequence

	sequence frame_takes_s;
		frame_start && pend_q && !(wr_en && sel_src);
	endsequence

	pend_set_a: assert property (src_write_pend_s |=> pend_q)
		else $error("pending bit not set after start address write");

	pend_clear_a: assert property (frame_takes_s |=> !pend_q)
		else $error("pending bit not cleared at frame start");

	active_load_a: assert property (
		$changed(src_active_q) |-> $past(frame_start && pend_q))
		else $error("active start address changed outside frame start");

	fetch_start_a: assert property (
		frame_takes_s |=> win2_fetch_addr == $past(src_shadow_q))
		else $error("fetch did not start at new source address");

	line_step_a: assert property (
		win2_line_adv && !frame_start |=>
		win2_fetch_addr == AW'($past(win2_fetch_addr) + $past(line_ofs_q)))
		else $error("line address did not advance by offset");

	top_left_a: assert property (
		wr_en && sel_lt |=> win2_bounds.top == $past(pwdata[26:16]) &&
		win2_bounds.left == $past(pwdata[10:0]))
		else $error("top or left boundary not taken from write");

	bottom_right_a: assert property (
		wr_en && sel_rb |=> win2_bounds.bottom == $past(pwdata[26:16]) &&
		win2_bounds.right == $past(pwdata[10:0]))
		else $error("bottom or right boundary not taken from write");

	line_width_a: assert property (
		wr_en && sel_wo |=> win2_line_width == $past(pwdata[25:16]))
		else $error("line width not taken from write");

	unity_horiz_a: assert property (
		pixel_step && w2_stretch_q.horiz == 8'h00 |-> win2_pix_adv)
		else $error("zero horizontal factor did not step every pixel");

	unity_vert_a: assert property (
		line_step && w1_stretch_q.vert == 8'h00 |-> win1_line_adv)
		else $error("zero vertical factor did not step every line");

	unmapped_err_a: assert property (
		psel && penable && !mapped |-> pslverr && pready)
		else $error("unmapped access without error answer");

endmodule : video_window_overlay_regs

// File: video_window_overlay_regs_bench.sv
// Purpose: self-checking bench for the overlay window register bank
// Assumes: zero-wait APB slave, display strobes driven by the bench
// Notes: register cases run from a table, strobe cases by hand after it
`timescale 1ns/1ns
module video_window_overlay_regs_bench;
	typedef struct {
		logic [7:0] a;
		logic [31:0] wd;
		logic [31:0] rd;
		logic err;
	} row_t;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] stb = 4'h0;
	logic field_odd = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	overlay_regs_pkg::bounds_t win2_bounds;
	logic [18:0] win2_fetch_addr;
	logic [9:0] win2_line_width;
	logic win2_pix_adv;
	logic win2_line_adv;
	logic win1_pix_adv;
	logic win1_line_adv;
	logic start_addr_pending;
	int bad_count = 0;
	int samples_checked = 0;
	row_t rows [8];

	// Clock, 50 ns period
	always #25 pclk = ~pclk;

	video_window_overlay_regs #(.ADDR_W(8)) video_window_overlay_regs_i (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.frame_start(stb[0]),
		.field_start(stb[1]),
		.field_odd(field_odd),
		.pixel_step(stb[2]),
		.line_step(stb[3]),
		.win2_bounds(win2_bounds),
		.win2_fetch_addr(win2_fetch_addr),
		.win2_line_width(win2_line_width),
		.win2_pix_adv(win2_pix_adv),
		.win2_line_adv(win2_line_adv),
		.win1_pix_adv(win1_pix_adv),
		.win1_line_adv(win1_line_adv),
		.start_addr_pending(start_addr_pending)
	);

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			$display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
			bad_count++;
		end
	endtask : check

	// Verdict and end of run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	// One APB transfer; waits on pready, never on a fixed count
	task automatic xfer(input logic wr, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// No wait limit here; the watchdog ends a hung transfer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle so the next setup never lands in the same step
		@(posedge pclk);
	endtask : xfer

	// Pulse one strobe n times, counting adv pulses of both windows
	task automatic strobe(input int k, input int n, output int c2,
			output int c1);
		c2 = 0;
		c1 = 0;
		repeat (n) begin
			stb <= 4'h1 << k;
			@(negedge pclk);
			c2 += (k == 2) ? int'(win2_pix_adv) : int'(win2_line_adv);
			c1 += (k == 2) ? int'(win1_pix_adv) : int'(win1_line_adv);
			@(posedge pclk);
			stb <= 4'h0;
			@(posedge pclk);
		end
	endtask : strobe

	// Watchdog, well beyond the roughly 150 cycles the tests need
	initial begin
		repeat (3000) @(posedge pclk);
		bad_count++;
		give_verdict();
	end

	initial begin
		logic [31:0] rd;
		logic err;
		int c2;
		int c1;
		// Reserved bits read back as zero; unmapped places refuse
		rows = '{
			'{8'h24, 32'ha1b2_c3d4, 32'ha1b2_c3d4, 1'b0},
			'{8'h28, 32'hffff_ffff, 32'h07ff_07ff, 1'b0},
			'{8'h2c, 32'h1234_5678, 32'h0234_0678, 1'b0},
			'{8'h30, 32'hffff_ffff, 32'h000f_ffff, 1'b0},
			'{8'h34, 32'hffff_ffff, 32'h03ff_03ff, 1'b0},
			'{8'h38, 32'h5a5a_a5a5, 32'h5a5a_a5a5, 1'b0},
			'{8'h3c, 32'hffff_ffff, 32'h0000_0000, 1'b1},
			'{8'h00, 32'hffff_ffff, 32'h0000_0000, 1'b1}
		};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(32'(start_addr_pending), 32'h0000_0000);
		xfer(1'b0, 8'h38, 32'h0000_0000, rd, err);
		check(rd, 32'h0000_0000);
		xfer(1'b0, 8'h24, 32'h0000_0000, rd, err);
		check(rd, 32'h0000_0000);
		foreach (rows[i]) begin
			xfer(1'b1, rows[i].a, rows[i].wd, rd, err);
			check(32'(err), 32'(rows[i].err));
			xfer(1'b0, rows[i].a, 32'h0000_0000, rd, err);
			check(rd, rows[i].rd);
			check(32'(err), 32'(rows[i].err));
		end
		check(32'(win2_bounds.top), 32'h0000_07ff);
		check(32'(win2_bounds.left), 32'h0000_07ff);
		check(32'(win2_bounds.bottom), 32'h0000_0234);
		check(32'(win2_bounds.right), 32'h0000_0678);
		check(32'(win2_line_width), 32'h0000_03ff);
		check(32'(start_addr_pending), 32'h0000_0001);
		check(32'(win2_fetch_addr), 32'h0000_0000);
		strobe(0, 1, c2, c1);
		check(32'(start_addr_pending), 32'h0000_0000);
		check(32'(win2_fetch_addr), 32'h0007_ffff);
		// Unit factors, line offset 0x10, new start 0x100
		xfer(1'b1, 8'h38, 32'h0000_0000, rd, err);
		xfer(1'b1, 8'h24, 32'h0000_0000, rd, err);
		xfer(1'b1, 8'h34, 32'h0005_0010, rd, err);
		xfer(1'b1, 8'h30, 32'h0008_0100, rd, err);
		check(32'(start_addr_pending), 32'h0000_0001);
		strobe(0, 1, c2, c1);
		check(32'(start_addr_pending), 32'h0000_0000);
		check(32'(win2_fetch_addr), 32'h0000_0100);
		strobe(3, 3, c2, c1);
		check(32'(c2), 32'h0000_0003);
		check(32'(c1), 32'h0000_0003);
		check(32'(win2_fetch_addr), 32'h0000_0130);
		strobe(2, 3, c2, c1);
		check(32'(c2), 32'h0000_0003);
		check(32'(c1), 32'h0000_0003);
		// Address written without the pending bit stays unused
		xfer(1'b1, 8'h30, 32'h0000_0200, rd, err);
		check(32'(start_addr_pending), 32'h0000_0000);
		strobe(0, 1, c2, c1);
		check(32'(win2_fetch_addr), 32'h0000_0100);
		// Half-rate stepping, window one at quarter rate across pixels and one to one down lines
		xfer(1'b1, 8'h38, 32'h0000_8080, rd, err);
		// pixel enlargement set to four to one, lines one to one
		xfer(1'b1, 8'h24, 32'h0000_4000, rd, err);
		strobe(1, 1, c2, c1);
		strobe(2, 4, c2, c1);
		check(32'(c2), 32'h0000_0002);
		check(32'(c1), 32'h0000_0001);
		strobe(3, 4, c2, c1);
		check(32'(c2), 32'h0000_0002);
		check(32'(c1), 32'h0000_0004);
		// Odd field seed makes the first line a repeat
		xfer(1'b1, 8'h38, 32'h8000_8080, rd, err);
		xfer(1'b1, 8'h24, 32'h8000_0080, rd, err);
		field_odd <= 1'b1;
		strobe(1, 1, c2, c1);
		strobe(3, 1, c2, c1);
		check(32'(c2), 32'h0000_0000);
		check(32'(c1), 32'h0000_0000);
		// Write in a frame-start cycle wins; old address drives this frame
		fork
			xfer(1'b1, 8'h30, 32'h0008_0300, rd, err);
			begin
				@(posedge pclk);
				stb <= 4'h1;
				@(posedge pclk);
				stb <= 4'h0;
			end
		join
		check(32'(start_addr_pending), 32'h0000_0001);
		check(32'(win2_fetch_addr), 32'h0000_0100);
		strobe(0, 1, c2, c1);
		check(32'(start_addr_pending), 32'h0000_0000);
		check(32'(win2_fetch_addr), 32'h0000_0300);
		// Reset in mid-run clears every register and the pending flag
		xfer(1'b1, 8'h30, 32'h0008_0400, rd, err);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(32'(start_addr_pending), 32'h0000_0000);
		check(32'(win2_fetch_addr), 32'h0000_0000);
		check(32'(win2_bounds.top), 32'h0000_0000);
		xfer(1'b0, 8'h38, 32'h0000_0000, rd, err);
		check(rd, 32'h0000_0000);
		xfer(1'b0, 8'h30, 32'h0000_0000, rd, err);
		check(rd, 32'h0000_0000);
		give_verdict();
	end
endmodule : video_window_overlay_regs_bench
